//--- shared/stepdir_pkg.sv
// Constants and carrier types for the step/direction sequencer
package stepdir_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_CHOP = 5'h00;
  localparam logic [4:0] ADDR_CURR = 5'h04;
  localparam logic [4:0] ADDR_STAT = 5'h08;
  localparam logic [4:0] ADDR_IVAL = 5'h0c;
  localparam logic [4:0] ADDR_INT_STAT = 5'h10;
  localparam logic [4:0] ADDR_INT_CLR = 5'h14;
  localparam logic [4:0] ADDR_INT_EN = 5'h18;

  // Field positions
  localparam int CHOP_MRES_LSB = 0;
  localparam int CHOP_INTPOL_BIT = 4;
  localparam int CHOP_DEDGE_BIT = 5;
  localparam int CURR_HOLD_LSB = 0;
  localparam int CURR_RUN_LSB = 8;
  localparam int STAT_STST_BIT = 16;
  localparam int INT_STST = 0;
  localparam int INT_REALIGN = 1;
  localparam int INT_W = 2;

  // Reset values
  localparam logic [3:0] MRES_RESET = 4'h0;
  localparam logic [4:0] HOLD_RESET = 5'h08;
  localparam logic [4:0] RUN_RESET = 5'h1f;

  // Resolution and timing
  localparam logic [3:0] MRES_FULL = 4'h8;
  localparam int STST_CYCLES_DEFAULT = 2 ** 20;
  localparam int SINE_PEAK = 248;

  typedef struct packed {
    logic [3:0] mres;
    logic intpol;
    logic dedge;
  } chop_cfg_s;

  typedef struct packed {
    logic signed [8:0] a;
    logic signed [8:0] b;
    logic [4:0] scale;
  } coil_drive_s;

  // Quarter-wave magnitude, rational sine approximation, t in 0..256
  function automatic logic [7:0] quarter_sine(input int t);
    int p;
    p = t * (512 - t);
    return 8'((SINE_PEAK * 4 * p) / (327680 - p));
  endfunction : quarter_sine

endpackage : stepdir_pkg

//--- verilog/step_dir_microstep_sequencer.sv
// Step/direction front end with microstep sequencer and interpolator
// Contract
// - Double-edge mode counts both step edges
// - Synchronise step and direction before use
// - Sine table spans four full steps
// - Direction low adds, high subtracts width
// - Step width doubles per coarser resolution
// - Coarser resolution snaps counter to grid
// - Full step visits 128, 384, 640, 896
// - Full-step positions give equal coil currents
// - Coarse grids offset by half the stride
// - Interpolation answers each edge with microsteps
// - One step expands to 1..256 microsteps
// - Interpolator runs only when enabled
// - Microstep spacing is measured period divided
// - Interval saturates; slow rate flags standstill
// - Standstill selects hold current
// - Next active edge clears standstill
// - New rate adopted; outstanding microsteps dropped
//
// Implementation choices: the register offsets and the address-and-strobe port.
module step_dir_microstep_sequencer
  import stepdir_pkg::*;
#(
  parameter int STST_LIMIT = STST_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Step and direction pins
  input wire logic step_in,
  input wire logic dir_in,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Coil drive and status
  output coil_drive_s drive,
  output logic [9:0] mscnt,
  output logic standstill,
  output logic irq
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  localparam logic [20:0] LIMIT = 21'(STST_LIMIT);

  chop_cfg_s cfg;
  logic [4:0] hold_scale;
  logic [4:0] run_scale;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;

  // Pin synchronisers
  logic step_meta;
  logic step_sync;
  logic step_prev;
  logic dir_meta;
  logic dir_sync;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      step_meta <= 1'b0;
      step_sync <= 1'b0;
      step_prev <= 1'b0;
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      step_meta <= step_in;
      step_sync <= step_meta;
      step_prev <= step_sync;
      dir_meta <= dir_in;
      dir_sync <= dir_meta;
    end
  end

  // Edge selection; a pin held high through reset reads as one rise
  wire step_rise = step_sync & ~step_prev;
  wire step_toggle = step_sync ^ step_prev;
  wire active = cfg.dedge ? step_toggle : step_rise;

  // Resolution, step width and grid
  logic [3:0] prev_mres;
  wire [3:0] mres_eff = (cfg.mres > MRES_FULL) ? MRES_FULL : cfg.mres;
  wire [9:0] width = 10'h1 << mres_eff;
  wire realign = mres_eff > prev_mres;
  // Keep the stride block, sit at its middle: never 0 or peak current
  wire [9:0] aligned = (mscnt & ~(width - 10'h1)) | (width >> 1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_mres <= MRES_RESET;
    end else begin
      prev_mres <= mres_eff;
    end
  end

  // Step interval measurement and standstill
  logic [20:0] step_timer;
  logic [20:0] last_interval;
  wire timer_full = step_timer == LIMIT;
  wire stst_event = !active && step_timer == LIMIT - 21'h1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      step_timer <= 21'h0;
      last_interval <= LIMIT;
      standstill <= 1'b0;
    end else if (active) begin
      step_timer <= 21'h1;
      last_interval <= step_timer;
      standstill <= 1'b0;
    end else begin
      if (!timer_full) begin
        step_timer <= step_timer + 21'h1;
      end
      if (stst_event) begin
        standstill <= 1'b1;
      end
    end
  end

  // Interpolator
  logic [8:0] remaining;
  logic [20:0] micro_timer;
  logic [20:0] spacing;
  logic interp_dir;
  // Spacing comes from the period that just ended, so a rate change
  // takes one input period to show
  wire [20:0] spacing_calc = step_timer >> mres_eff;
  wire [20:0] spacing_new = (spacing_calc == 21'h0) ? 21'h1 : spacing_calc;
  wire micro_tick = cfg.intpol && remaining != 9'h0 &&
                    micro_timer == 21'h0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      remaining <= 9'h0;
      micro_timer <= 21'h0;
      spacing <= 21'h1;
      interp_dir <= 1'b0;
    end else if (realign || !cfg.intpol) begin
      remaining <= 9'h0;
      micro_timer <= 21'h0;
    end else if (active) begin
      // Outstanding microsteps of the old edge are dropped here
      remaining <= width[8:0];
      micro_timer <= 21'h0;
      spacing <= spacing_new;
      interp_dir <= dir_sync;
    end else if (micro_tick) begin
      remaining <= remaining - 9'h1;
      micro_timer <= spacing - 21'h1;
    end else if (micro_timer != 21'h0) begin
      micro_timer <= micro_timer - 21'h1;
    end
  end

  // Microstep counter; a step coinciding with a realign is dropped
  wire [9:0] step_next = dir_sync ? mscnt - width : mscnt + width;
  wire [9:0] micro_next = interp_dir ? mscnt - 10'h1 : mscnt + 10'h1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mscnt <= 10'h0;
    end else if (realign) begin
      mscnt <= aligned;
    end else if (!cfg.intpol && active) begin
      mscnt <= step_next;
    end else if (micro_tick) begin
      mscnt <= micro_next;
    end
  end

  // Sine table: one quarter stored, 1024 positions by symmetry
  logic [7:0] qtab [0:256];
  for (genvar g = 0; g <= 256; g++) begin : g_qtab
    assign qtab[g] = quarter_sine(g);
  end

  function automatic logic signed [8:0] coil_value(input logic [9:0] idx);
    logic [7:0] mag;
    mag = idx[8] ? qtab[9'd256 - {1'b0, idx[7:0]}] : qtab[idx[7:0]];
    return idx[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : coil_value

  wire [9:0] cos_idx = mscnt + 10'h100;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drive <= '0;
    end else begin
      drive.a <= coil_value(mscnt);
      drive.b <= coil_value(cos_idx);
      drive.scale <= standstill ? hold_scale : run_scale;
    end
  end

  // Register decode
  wire wr_chop = wr && addr == ADDR_CHOP;
  wire wr_curr = wr && addr == ADDR_CURR;
  wire wr_clr = wr && addr == ADDR_INT_CLR;
  wire wr_en = wr && addr == ADDR_INT_EN;
  wire [INT_W-1:0] clr_mask = wr_clr ? wdata[INT_W-1:0] : '0;
  wire [INT_W-1:0] events = {realign, stst_event};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg <= '{mres: MRES_RESET, intpol: 1'b0, dedge: 1'b0};
      hold_scale <= HOLD_RESET;
      run_scale <= RUN_RESET;
      int_en <= '0;
    end else begin
      if (wr_chop) begin
        cfg.mres <= wdata[CHOP_MRES_LSB +: 4];
        cfg.intpol <= wdata[CHOP_INTPOL_BIT];
        cfg.dedge <= wdata[CHOP_DEDGE_BIT];
      end
      if (wr_curr) begin
        hold_scale <= wdata[CURR_HOLD_LSB +: 5];
        run_scale <= wdata[CURR_RUN_LSB +: 5];
      end
      if (wr_en) begin
        int_en <= wdata[INT_W-1:0];
      end
    end
  end

  // Sticky events: a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~clr_mask) | events;
      irq <= |(int_stat & int_en);
    end
  end

  // Read mux
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (addr == ADDR_CHOP) begin
      next_rdata[CHOP_MRES_LSB +: 4] = cfg.mres;
      next_rdata[CHOP_INTPOL_BIT] = cfg.intpol;
      next_rdata[CHOP_DEDGE_BIT] = cfg.dedge;
    end else if (addr == ADDR_CURR) begin
      next_rdata[CURR_HOLD_LSB +: 5] = hold_scale;
      next_rdata[CURR_RUN_LSB +: 5] = run_scale;
    end else if (addr == ADDR_STAT) begin
      next_rdata[9:0] = mscnt;
      next_rdata[STAT_STST_BIT] = standstill;
    end else if (addr == ADDR_IVAL) begin
      next_rdata[20:0] = last_interval;
    end else if (addr == ADDR_INT_STAT) begin
      next_rdata[INT_W-1:0] = int_stat;
    end else if (addr == ADDR_INT_EN) begin
      next_rdata[INT_W-1:0] = int_en;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0;
    end
  end

  // Checks
  a_sync_latency: assert property (
    active |-> $past(step_in, 2) != $past(step_in, 3))
    else $error("step acted on without two-stage sync");

  a_rising_only: assert property (
    (!cfg.dedge && !step_sync && step_prev) |-> !active)
    else $error("falling edge counted in single-edge mode");

  a_both_edges: assert property (
    (cfg.dedge && step_toggle) |-> active)
    else $error("edge missed in double-edge mode");

  a_step_forward: assert property (
    (active && !cfg.intpol && !realign && !dir_sync)
    |=> mscnt == $past(mscnt) + $past(width))
    else $error("forward step moved counter wrongly");

  a_step_back: assert property (
    (active && !cfg.intpol && !realign && dir_sync)
    |=> mscnt == $past(mscnt) - $past(width))
    else $error("reverse step moved counter wrongly");

  a_full_grid: assert property (
    (realign && mres_eff == MRES_FULL) |=> mscnt[7:0] == 8'h80)
    else $error("full-step realign off grid");

  a_equal_coils: assert property (
    ($past(mscnt[7:0]) == 8'h80) |->
    (drive.a == drive.b || drive.a == -drive.b))
    else $error("full-step coil currents differ");

  a_interp_load: assert property (
    (active && cfg.intpol && !realign)
    |=> remaining == $past(width[8:0]) && micro_tick)
    else $error("interpolator burst not started");

  a_interp_off: assert property (
    !cfg.intpol |-> !micro_tick)
    else $error("microstep while interpolation off");

  a_stst_set: assert property (
    stst_event |=> standstill && int_stat[INT_STST])
    else $error("standstill not flagged at limit");

  a_stst_clear: assert property (
    active |=> !standstill)
    else $error("standstill not cleared by step");

  a_hold_current: assert property (
    (standstill && $stable(hold_scale))
    |=> drive.scale == $past(hold_scale))
    else $error("hold current not applied");

  a_run_current: assert property (
    (!standstill && $stable(run_scale))
    |=> drive.scale == $past(run_scale))
    else $error("run current not applied while moving");

  a_grid_middle: assert property (
    realign |=> (mscnt & ($past(width) - 10'h1)) == ($past(width) >> 1))
    else $error("realign not at middle of stride");

  a_micro_up: assert property (
    (micro_tick && !realign && !interp_dir)
    |=> mscnt == $past(mscnt) + 10'h1)
    else $error("forward microstep moved counter wrongly");

  a_micro_down: assert property (
    (micro_tick && !realign && interp_dir)
    |=> mscnt == $past(mscnt) - 10'h1)
    else $error("reverse microstep moved counter wrongly");

  a_micro_gap: assert property (
    (micro_tick && !active && spacing > 21'h1) |=> !micro_tick)
    else $error("microsteps closer than measured spacing");

  a_mscnt_quiet: assert property (
    (!realign && !active && !micro_tick) |=> $stable(mscnt))
    else $error("counter moved without step or realign");

  a_stst_hold: assert property (
    (standstill && !active) |=> standstill)
    else $error("standstill dropped without a step");

  a_stst_timing: assert property (
    $rose(standstill) |-> $past(step_timer) == LIMIT - 21'h1)
    else $error("standstill flagged before the limit");

  c_realign: cover property (realign);
  c_standstill: cover property ($rose(standstill));
  c_interp_burst: cover property (micro_tick ##1 micro_tick);
  c_dedge_fall: cover property (cfg.dedge && active && !step_sync);

endmodule : step_dir_microstep_sequencer

//--- testbench/step_source.sv
// Motion controller model driving the step and direction pins
module step_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command from the bench
  input wire logic go,
  input wire logic dir_cmd,
  input wire logic toggle,
  input wire logic [7:0] high_len,
  // Pins and status
  output logic step_in,
  output logic dir_in,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      step_in <= 1'b0;
      dir_in <= 1'b0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (go && !busy) begin
      dir_in <= dir_cmd;
      busy <= 1'b1;
      cnt <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      // Direction settles five cycles ahead of the edge
      if (cnt == 8'h04) step_in <= toggle ? !step_in : 1'b1;
      if (cnt == 8'h04 + high_len) begin
        step_in <= toggle ? step_in : 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : step_source

//--- testbench/step_dir_microstep_sequencer_tb.sv
// Self-checking bench for the step/direction microstep sequencer
module step_dir_microstep_sequencer_tb import stepdir_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 64;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic dir_cmd = 1'b0;
  logic toggle = 1'b0;
  logic [7:0] high_len = 8'h02;
  logic step_in, dir_in, busy, standstill, irq;
  logic [31:0] rdata;
  logic [9:0] mscnt;
  coil_drive_s drive;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int pos = 0;
  int mres = 0;

  always #2.5 mclk = ~mclk;

  step_dir_microstep_sequencer #(.STST_LIMIT(LIMIT))
    i_step_dir_microstep_sequencer (
    .mclk(mclk), .rstn(rstn), .step_in(step_in), .dir_in(dir_in),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .drive(drive), .mscnt(mscnt), .standstill(standstill), .irq(irq));

  step_source i_step_source (
    .mclk(mclk), .rstn(rstn), .go(go), .dir_cmd(dir_cmd),
    .toggle(toggle), .high_len(high_len), .step_in(step_in),
    .dir_in(dir_in), .busy(busy));

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Position compare, sampled clear of the edge
  task automatic chk_mscnt();
    #1;
    num_checks++;
    if (mscnt !== 10'(pos)) begin
      mismatches++;
      $display("ERROR %0t mscnt %0d expected %0d", $time, mscnt, pos);
    end
    @(posedge mclk);
  endtask : chk_mscnt

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    // Idle edge so a following write never reassigns the strobe
    @(posedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk_word(rdata, exp);
    @(posedge mclk);
  endtask : rd_reg

  function automatic int width(input int m);
    return 1 << (m > 8 ? 8 : m);
  endfunction : width

  task automatic set_cfg(input int m, input logic ip, input logic de);
    if (m > mres) pos = (pos & ~(width(m) - 1)) | width(m) / 2;
    mres = m;
    wr_reg(ADDR_CHOP, {26'h0, de, ip, 4'(m)});
    repeat (2) @(posedge mclk);
  endtask : set_cfg

  // Mid nonzero: look for a partly interpolated move that many cycles in
  task automatic step(input logic d, input int mid);
    int np;
    np = (pos + (d ? -width(mres) : width(mres))) & 1023;
    dir_cmd <= d;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (mid) @(posedge mclk);
    if (mid > 0) begin
      #1 chk_word(32'(mscnt !== 10'(pos) && mscnt !== 10'(np)), 1);
    end
    @(posedge mclk);
    while (busy) @(posedge mclk);
    repeat (6) @(posedge mclk);
    pos = np;
  endtask : step

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'h7b74));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_reg(ADDR_CHOP, 32'h0);
    rd_reg(ADDR_CURR, 32'h1f08);
    rd_reg(5'h1c, 32'h0);
    chk_mscnt();
    // Each coarser resolution realigns, then steps a random way
    for (int m = 0; m <= 8; m++) begin
      set_cfg(m, 1'b0, 1'b0);
      chk_mscnt();
      step(1'($urandom_range(1)), 0);
      chk_mscnt();
    end
    for (int i = 0; i < 5; i++) begin
      step(1'b0, 0);
      #1 chk_word(32'(drive.a === drive.b || drive.a === -drive.b), 1);
      chk_mscnt();
    end
    set_cfg(0, 1'b0, 1'b1);
    toggle <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      step(1'b1, 0);
      chk_mscnt();
    end
    toggle <= 1'b0;
    // Period under the standstill limit, long enough for a whole burst
    high_len <= 8'd46;
    set_cfg(2, 1'b1, 1'b0);
    wr_reg(ADDR_CURR, 32'h1f05);
    wr_reg(ADDR_INT_EN, 32'h1);
    wr_reg(ADDR_INT_CLR, 32'h3);
    repeat (LIMIT + 8) @(posedge mclk);
    // Standstill and irq high, hold scale 5
    #1 chk_word(32'({standstill, irq, drive.scale}), 32'h65);
    @(posedge mclk);
    rd_reg(ADDR_INT_STAT, 32'h1);
    rd_reg(ADDR_STAT, {15'h0, 1'b1, 6'h0, 10'(pos)});
    wr_reg(ADDR_INT_CLR, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk_word({31'h0, irq}, 32'h0);
    @(posedge mclk);
    step(1'b0, 16);
    #1 chk_word(32'({standstill, drive.scale}), 32'h1f);
    chk_mscnt();
    step(1'b1, 16);
    chk_mscnt();
    high_len <= 8'h02;
    set_cfg(2, 1'b0, 1'b0);
    step(1'b0, 0);
    chk_mscnt();
    complete_run();
  end
endmodule : step_dir_microstep_sequencer_tb
